// [logic/nvsl_top.sv]
// loader of nonvolatile protection and option bytes with key unlock
// assumes a flash read port with data one cycle after the read strobe
// assumes the flash command logic pulses a verified-blank indication
`timescale 1ns/1ns
`default_nettype none
`include "nvsl_cfg.svh"
module nvsl_top
	import nvsl_pkg::*;
(
	input wire logic mclk_i, // system clock
	input wire logic nrst_i, // async reset, low
	input wire logic ce_i, // clock enable
	input wire logic [15:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, next cycle
	input wire logic cpu_secure_i, // code runs from secure memory
	input wire logic bdm_acc_i, // access comes from debug
	input wire logic blank_ok_i, // mass erase verified blank
	output logic [15:0] nv_addr_o, // flash byte address
	output logic nv_rd_o, // flash read strobe
	input wire logic [7:0] nv_rdata_i, // flash data, next cycle
	output logic secure_o, // memory secured
	output logic key_enable_bit_o, // backdoor key allowed
	output logic vector_redirect_disable_o, // redirect off
	output logic [6:0] protect_boundary_field_o, // protect limit
	output logic protect_disable_bit_o, // protection off
	output logic [7:0] clock_trim_value_o, // clock trim
	output logic fine_trim_bit_o, // fine trim
	output logic load_done_o // working copies valid
);
	nvsl_key_if kif ();

	nvsl_state_e state_q;
	logic [3:0] step_q;
	nvsl_addr_t step_addr;
	nvsl_byte_t option_q;
	nvsl_byte_t prot_q;
	logic prot_locked_q;
	nvsl_byte_t ctrim_q;
	logic fine_trim_bit_q;
	logic [63:0] key_q;
	logic key_access_bit_q;
	logic unlock_q;
	logic erased_q;
	logic keybad_q;
	logic reject_q;
	nvsl_byte_t rdata_q;
	nvsl_byte_t rd_mux;
	logic hp_sel;
	logic key_sel;
	logic loaded;
	logic sec_open;
	logic key_try;
	logic key_ok;
	logic [7:0] status;

	// decode of the high-page block
	assign hp_sel = (addr_i >= `NVSL_HP_BASE) &&
		(addr_i <= `NVSL_HP_LAST);
	assign key_sel = (addr_i >= `NVSL_NV_KEY0) &&
		(addr_i <= `NVSL_NV_KEY7);
	assign loaded = (state_q == NVSL_READY);

	// address of each load step, trim bytes first, options last
	always_comb begin
		case (step_q)
			4'h0: step_addr = `NVSL_NV_FINE_TRIM_BIT;
			4'h1: step_addr = `NVSL_NV_CTRIM;
			4'h2, 4'h3, 4'h4, 4'h5,
			4'h6, 4'h7, 4'h8, 4'h9: begin
				step_addr = `NVSL_NV_KEY0 + {12'h000, step_q - 4'h2};
			end
			4'hA: step_addr = `NVSL_NV_PROT;
			4'hB: step_addr = `NVSL_NV_OPT;
			default: step_addr = `NVSL_NV_OPT;
		endcase
	end

	// load sequencer: issue a read, capture it, move on
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= NVSL_ISSUE;
			step_q <= 4'h0;
		end else if (ce_i) begin
			case (state_q)
				NVSL_ISSUE: begin
					state_q <= NVSL_CAPT;
				end
				NVSL_CAPT: begin
					if (step_q == `NVSL_LOAD_CNT - 4'h1) begin
						state_q <= NVSL_READY;
					end else begin
						state_q <= NVSL_ISSUE;
						step_q <= step_q + 4'h1;
					end
				end
				NVSL_READY: begin
					state_q <= NVSL_READY;
				end
				default: begin
					state_q <= NVSL_ISSUE;
					step_q <= 4'h0;
				end
			endcase
		end
	end

	// flash read port driven by the sequencer
	assign nv_rd_o = (state_q == NVSL_ISSUE) && ce_i;
	assign nv_addr_o = step_addr;

	// working option byte filled from its stored copy
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			option_q <= `NVSL_RST_OPTION;
		end else if (ce_i && state_q == NVSL_CAPT &&
			step_addr == `NVSL_NV_OPT) begin
			option_q <= nv_rdata_i;
		end
	end

	// working protection: loaded at reset, one later software write
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prot_q <= `NVSL_RST_PROT;
			prot_locked_q <= 1'b0;
		end else if (ce_i) begin
			if (state_q == NVSL_CAPT && step_addr == `NVSL_NV_PROT) begin
				prot_q <= nv_rdata_i;
			end else if (loaded && wr_i && !prot_locked_q &&
				addr_i == `NVSL_OFS_PROT) begin
				prot_q <= wdata_i;
				prot_locked_q <= 1'b1;
			end
		end
	end

	// trim bytes, only bit 0 of the fine trim byte is kept
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrim_q <= `NVSL_RST_BYTE;
			fine_trim_bit_q <= 1'b0;
		end else if (ce_i && state_q == NVSL_CAPT) begin
			if (step_addr == `NVSL_NV_CTRIM) begin
				ctrim_q <= nv_rdata_i;
			end
			if (step_addr == `NVSL_NV_FINE_TRIM_BIT) begin
				fine_trim_bit_q <= nv_rdata_i[`NVSL_BIT_FINE_TRIM_BIT];
			end
		end
	end

	// stored comparison key, byte 0 at the lowest address
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			key_q <= 64'h0000_0000_0000_0000;
		end else if (ce_i && state_q == NVSL_CAPT && step_q >= 4'h2 &&
			step_q <= 4'h9) begin
			key_q[(step_q - 4'h2)*8 +: 8] <= nv_rdata_i;
		end
	end

	// key access bit, software sets it to open an entry
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			key_access_bit_q <= 1'b0;
		end else if (ce_i && loaded && wr_i &&
			addr_i == `NVSL_OFS_KEY_ACCESS_BIT) begin
			key_access_bit_q <= wdata_i[`NVSL_BIT_KEY_ACCESS_BIT];
		end
	end

	// a key write counts only from secure user code, not debug
	assign key_try = ce_i && loaded && wr_i && key_sel && key_access_bit_q;
	assign key_ok = key_try && cpu_secure_i && !bdm_acc_i;

	// comparator hookup
	assign kif.ce = ce_i;
	assign kif.clr = !key_access_bit_q || (kif.full && !kif.hit);
	assign kif.we = key_ok;
	assign kif.idx = addr_i[2:0];
	assign kif.wdata = wdata_i;
	assign kif.stored = key_q;

	nvsl_key_cmp #(
		.NBYTES(`NVSL_KEY_BYTES)
	) u_key (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.kif(kif)
	);

	// unlock latch, only a reset takes it back
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			unlock_q <= 1'b0;
		end else if (ce_i && kif.hit &&
			option_q[`NVSL_BIT_KEY_ENABLE_BIT]) begin
			unlock_q <= 1'b1;
		end
	end

	// verified blank after mass erase lifts security until reset
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			erased_q <= 1'b0;
		end else if (ce_i && blank_ok_i) begin
			erased_q <= 1'b1;
		end
	end

	// sticky mismatch flag, a new mismatch beats the clear
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			keybad_q <= 1'b0;
		end else if (ce_i) begin
			if (kif.full && !kif.hit) begin
				keybad_q <= 1'b1;
			end else if (wr_i && addr_i == `NVSL_OFS_KEY_ACCESS_BIT &&
				wdata_i[`NVSL_BIT_KEY_ACCESS_BIT]) begin
				keybad_q <= 1'b0;
			end
		end
	end

	// sticky flag for refused key writes, set wins over clear
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reject_q <= 1'b0;
		end else if (ce_i) begin
			if (key_try && !key_ok) begin
				reject_q <= 1'b1;
			end else if (wr_i && addr_i == `NVSL_OFS_KEY_ACCESS_BIT &&
				wdata_i[`NVSL_BIT_KEY_ACCESS_BIT]) begin
				reject_q <= 1'b0;
			end
		end
	end

	// security decode of the two-bit field
	assign sec_open = (option_q[`NVSL_SEC_HI:`NVSL_SEC_LO] ==
		`NVSL_SEC_OPEN);
	assign secure_o = !(sec_open || unlock_q || erased_q);

	// status word
	always_comb begin
		status = 8'h00;
		status[`NVSL_ST_SECURE] = secure_o;
		status[`NVSL_ST_UNLOCK] = unlock_q;
		status[`NVSL_ST_LOADED] = loaded;
		status[`NVSL_ST_KEYBAD] = keybad_q;
		status[`NVSL_ST_REJECT] = reject_q;
	end

	// read mux; outside the block and reserved places read zero
	always_comb begin
		rd_mux = 8'h00;
		if (hp_sel) begin
			case (addr_i)
				`NVSL_OFS_OPTION: rd_mux = option_q;
				`NVSL_OFS_KEY_ACCESS_BIT: begin
					rd_mux[`NVSL_BIT_KEY_ACCESS_BIT] = key_access_bit_q;
				end
				`NVSL_OFS_PROT: rd_mux = prot_q;
				`NVSL_OFS_STATUS: rd_mux = status;
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// read data registered, valid the cycle after the strobe only
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 8'h00;
		end else if (ce_i) begin
			rdata_q <= rd_i ? rd_mux : 8'h00;
		end
	end

	assign rdata_o = rdata_q;

	// option and protection fields out to the rest of the chip
	assign key_enable_bit_o = option_q[`NVSL_BIT_KEY_ENABLE_BIT];
	assign vector_redirect_disable_o = option_q[`NVSL_BIT_NORED];
	assign protect_boundary_field_o = prot_q[7:1];
	assign protect_disable_bit_o = prot_q[`NVSL_BIT_PROTECT_DISABLE_BIT];
	assign clock_trim_value_o = ctrim_q;
	assign fine_trim_bit_o = fine_trim_bit_q;
	assign load_done_o = loaded;
endmodule
`default_nettype wire

// [logic/nvsl_cfg.svh]
// constants of the nonvolatile option and security loader
// assumes byte-wide registers and a 16-bit cpu address space
//
// Contract
// - On every reset the stored protection and option bytes are copied into the working protection and option registers.
// - An eight-byte comparison key lives in consecutive nonvolatile bytes for unlocking secured memory.
// - The key may lift security only while the key enable bit reads one.
// - Key entry is taken only from user code in secure memory and never through background debug access.
// - With the key disabled, security is lifted only after a verified blank mass erase.
// - A security field of one-zero means unsecured after reset; every other value means secured.
// - The high-page control registers decode in a block starting at 0x1800.
// - One nonvolatile byte holds the clock trim value and bit 0 of the byte before it the fine trim bit.
`ifndef NVSL_CFG_SVH
`define NVSL_CFG_SVH

// high-page block
`define NVSL_HP_BASE 16'h1800
`define NVSL_HP_LAST 16'h185F
`define NVSL_OFS_OPTION 16'h1821
`define NVSL_OFS_KEY_ACCESS_BIT 16'h1823
`define NVSL_OFS_PROT 16'h1824
`define NVSL_OFS_STATUS 16'h1827

// nonvolatile byte addresses
`define NVSL_NV_FINE_TRIM_BIT 16'hFFAE
`define NVSL_NV_CTRIM 16'hFFAF
`define NVSL_NV_KEY0 16'hFFB0
`define NVSL_NV_KEY7 16'hFFB7
`define NVSL_NV_PROT 16'hFFBD
`define NVSL_NV_OPT 16'hFFBF

// field positions
`define NVSL_BIT_KEY_ENABLE_BIT 7
`define NVSL_BIT_NORED 6
`define NVSL_SEC_HI 1
`define NVSL_SEC_LO 0
`define NVSL_BIT_KEY_ACCESS_BIT 5
`define NVSL_BIT_PROTECT_DISABLE_BIT 0
`define NVSL_BIT_FINE_TRIM_BIT 0
`define NVSL_SEC_OPEN 2'h2

// status bits
`define NVSL_ST_SECURE 0
`define NVSL_ST_UNLOCK 1
`define NVSL_ST_LOADED 2
`define NVSL_ST_KEYBAD 3
`define NVSL_ST_REJECT 4

// reset values, secured and unprotected until loaded
`define NVSL_RST_OPTION 8'h00
`define NVSL_RST_PROT 8'hFF
`define NVSL_RST_BYTE 8'h00

// load sequence length and key size
`define NVSL_LOAD_CNT 4'hC
`define NVSL_KEY_BYTES 8

`endif

// [logic/nvsl_pkg.sv]
// types of the nonvolatile option and security loader
// assumes nvsl_cfg.svh is on the include path
`default_nettype none
package nvsl_pkg;
	typedef logic [7:0] nvsl_byte_t;
	typedef logic [15:0] nvsl_addr_t;
	// one-hot load sequencer
	typedef enum logic [2:0] {
		NVSL_ISSUE = 3'b001,
		NVSL_CAPT = 3'b010,
		NVSL_READY = 3'b100
	} nvsl_state_e;
endpackage
`default_nettype wire

// [logic/nvsl_key_if.sv]
// carrier between the loader and its key comparator
// assumes a single clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface nvsl_key_if;
	import nvsl_pkg::*;
	logic ce;
	logic clr;
	logic we;
	logic [2:0] idx;
	nvsl_byte_t wdata;
	logic [63:0] stored;
	logic full;
	logic hit;
	modport ctl (output ce, clr, we, idx, wdata, stored, input full, hit);
	modport cmp (input ce, clr, we, idx, wdata, stored, output full, hit);
endinterface
`default_nettype wire

// [logic/nvsl_key_cmp.sv]
// entered key bytes and their comparison with the stored key
// assumes the controller only writes while entry is permitted
`timescale 1ns/1ns
`default_nettype none
module nvsl_key_cmp
	import nvsl_pkg::*;
#(
	parameter int NBYTES = 8
) (
	input wire logic mclk_i, // system clock
	input wire logic nrst_i, // async reset, low
	nvsl_key_if.cmp kif // controller side
);
	nvsl_byte_t entered_q [NBYTES];
	logic [NBYTES-1:0] filled_q;
	logic [NBYTES-1:0] eq;

	// capture each entered byte at its index
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			filled_q <= '0;
			for (int i = 0; i < NBYTES; i++) begin
				entered_q[i] <= 8'h00;
			end
		end else if (kif.ce) begin
			if (kif.clr) begin
				filled_q <= '0;
			end else if (kif.we) begin
				entered_q[kif.idx] <= kif.wdata;
				filled_q[kif.idx] <= 1'b1;
			end
		end
	end

	// byte-wise comparison, key byte 0 in the low lane
	for (genvar g = 0; g < NBYTES; g++) begin : g_eq
		assign eq[g] = (entered_q[g] == kif.stored[g*8 +: 8]);
	end

	assign kif.full = &filled_q;
	assign kif.hit = (&filled_q) && (&eq);
endmodule
`default_nettype wire

// [dv/nvsl_top_sva.sv]
// port assertions of the option and security loader
// assumes a bind to nvsl_top and a single clock domain
`timescale 1ns/1ns
`default_nettype none
module nvsl_top_sva (
	input wire logic mclk_i, // system clock
	input wire logic nrst_i, // async reset, low
	input wire logic ce_i, // clock enable
	input wire logic [15:0] addr_i, // register address
	input wire logic rd_i, // read strobe
	input wire logic [7:0] rdata_o, // read data
	input wire logic blank_ok_i, // verified blank
	input wire logic [15:0] nv_addr_o, // flash address
	input wire logic nv_rd_o, // flash read
	input wire logic [7:0] nv_rdata_i, // flash data
	input wire logic secure_o, // secured
	input wire logic key_enable_bit_o, // key allowed
	input wire logic vector_redirect_disable_o, // redirect off
	input wire logic [6:0] protect_boundary_field_o, // protect limit
	input wire logic protect_disable_bit_o, // protection off
	input wire logic [7:0] clock_trim_value_o, // clock trim
	input wire logic fine_trim_bit_o, // fine trim
	input wire logic load_done_o // working copies valid
);
	logic [7:0] nv_q;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// flash byte as the loader captured it
	always_ff @(posedge mclk_i) nv_q <= nv_rdata_i;
	// one load step: read issued, then data captured
	sequence s_cap(logic [15:0] a);
		nv_rd_o && ce_i && nv_addr_o == a ##1 ce_i;
	endsequence
	a_opt_copy: assert property (s_cap(16'hFFBF) |=>
		key_enable_bit_o == nv_q[7] && vector_redirect_disable_o == nv_q[6]
		&& load_done_o) else $error("option byte not copied");
	a_prot_copy: assert property (s_cap(16'hFFBD) |=>
		{protect_boundary_field_o, protect_disable_bit_o} == nv_q)
		else $error("protection byte not copied");
	a_sec_decode: assert property (s_cap(16'hFFBF) |=>
		secure_o == (nv_q[1:0] != 2'h2)) else $error("security decode wrong");
	a_trim_copy: assert property (s_cap(16'hFFAF) |=>
		clock_trim_value_o == nv_q && nv_addr_o == 16'hFFB0)
		else $error("clock trim not copied");
	a_fine_copy: assert property (s_cap(16'hFFAE) |=>
		fine_trim_bit_o == nv_q[0]) else $error("fine trim not copied");
	a_key_order: assert property (s_cap(16'hFFB7) |=>
		nv_rd_o && nv_addr_o == 16'hFFBD) else $error("key bytes misplaced");
	a_issue_capt: assert property (nv_rd_o && ce_i |=> !nv_rd_o)
		else $error("flash read not followed by capture");
	a_blank_open: assert property (blank_ok_i && ce_i |=> !secure_o)
		else $error("blank erase did not unsecure");
	a_unlock_hold: assert property (!secure_o |=> !secure_o)
		else $error("security came back before reset");
	a_keyoff_lock: assert property (load_done_o && !key_enable_bit_o
		&& secure_o && !blank_ok_i |=> secure_o)
		else $error("unlock with key disabled");
	a_outside_zero: assert property (rd_i && ce_i
		&& (addr_i < 16'h1800 || addr_i > 16'h185F) |=> rdata_o == 8'h00)
		else $error("read outside block not zero");
	a_read_option: assert property (rd_i && ce_i && load_done_o
		&& addr_i == 16'h1821 |=> rdata_o[7:2] ==
		{key_enable_bit_o, vector_redirect_disable_o, 4'h0})
		else $error("option read wrong");
endmodule
`default_nettype wire

// [dv/nvsl_flash_model.sv]
// flash holding the stored trim, key, protection and option bytes
// assumes data is wanted in the cycle after each read strobe
`timescale 1ns/1ns
`default_nettype none
module nvsl_flash_model (
	input wire logic mclk_i, // system clock
	input wire logic [15:0] nv_addr_i, // byte address
	input wire logic nv_rd_i, // read strobe
	input wire logic [7:0] opt_i, // stored option byte
	output logic [7:0] nv_rdata_o // data, cycle after strobe
);
	// answer a read next cycle, else scramble the stale byte
	always_ff @(posedge mclk_i) begin
		if (!nv_rd_i) begin
			nv_rdata_o <= ~nv_rdata_o;
		end else begin
			case (nv_addr_i)
				16'hFFAE: nv_rdata_o <= 8'h01;
				16'hFFAF: nv_rdata_o <= 8'h5C;
				16'hFFBD: nv_rdata_o <= 8'hB4;
				16'hFFBF: nv_rdata_o <= opt_i;
				default: nv_rdata_o <= nv_addr_i[7:0] - 8'h10;
			endcase
		end
	end
endmodule
`default_nettype wire

// [dv/tb_nvsl_top.sv]
// self-checking bench of the option and security loader
// assumes the flash model answers one cycle after each read strobe
`timescale 1ns/1ns
`default_nettype none
module tb_nvsl_top;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [15:0] addr_q = 16'h0000;
	logic [7:0] wdata_q = 8'h00;
	logic wr_q = 1'b0;
	logic rd_q = 1'b0;
	logic sec_q = 1'b0;
	logic bdm_q = 1'b0;
	logic blank_q = 1'b0;
	logic ce_q = 1'b1;
	logic [7:0] opt_q = 8'h81;
	logic [7:0] rdata, nv_rdata, ctrim;
	logic [15:0] nv_addr;
	logic nv_rd, secure, key_enable_bit, nored, pdis, fine_trim_bit, done;
	logic [6:0] pfs;
	int n_errors = 0;
	int cmp_count = 0;
	always #5 mclk_i = ~mclk_i;
	// loader and the flash behind it
	nvsl_top dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_q),
		.addr_i(addr_q), .wdata_i(wdata_q), .wr_i(wr_q), .rd_i(rd_q),
		.rdata_o(rdata), .cpu_secure_i(sec_q), .bdm_acc_i(bdm_q),
		.blank_ok_i(blank_q), .nv_addr_o(nv_addr), .nv_rd_o(nv_rd),
		.nv_rdata_i(nv_rdata), .secure_o(secure), .key_enable_bit_o(key_enable_bit),
		.vector_redirect_disable_o(nored), .protect_boundary_field_o(pfs),
		.protect_disable_bit_o(pdis), .clock_trim_value_o(ctrim),
		.fine_trim_bit_o(fine_trim_bit), .load_done_o(done));
	nvsl_flash_model flash_u (.mclk_i(mclk_i), .nv_addr_i(nv_addr),
		.nv_rd_i(nv_rd), .opt_i(opt_q), .nv_rdata_o(nv_rdata));
	// verdict and end of run
	task automatic summarize();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_q <= a;
		wdata_q <= d;
		wr_q <= 1'b1;
		@(posedge mclk_i);
		wr_q <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr_q <= a;
		rd_q <= 1'b1;
		@(posedge mclk_i);
		rd_q <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	// reset with a given stored option byte, wait for the load
	task automatic boot(input logic [7:0] o);
		int n;
		opt_q <= o;
		nrst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(posedge mclk_i);
			#1 n++;
		end
		if (n == 60) begin
			n_errors++;
			summarize();
		end
	endtask
	// eight key bytes, byte 3 spoiled by bad, then the outcome
	task automatic key(input logic [7:0] bad, input logic e);
		for (int i = 0; i < 8; i++) begin
			wr(16'hFFB0 + 16'(i), (8'hA0 + 8'(i)) ^ ((i == 3) ? bad : 8'h00));
		end
		repeat (3) @(posedge mclk_i);
		#1 chk("secure", secure, e);
	endtask
	initial begin
		for (int s = 0; s < 4; s++) begin
			boot({6'h10, 2'(s)});
			chk("secure", secure, s != 2);
			chk("redirect", nored, 1'b1);
			rd(16'h1821, {6'h10, 2'(s)});
		end
		boot(8'h81);
		chk("key_enable_bit", key_enable_bit, 1'b1);
		chk("prot", {pfs, pdis}, 8'hB4);
		chk("ctrim", ctrim, 8'h5C);
		chk("fine_trim_bit", fine_trim_bit, 1'b1);
		rd(16'h1824, 8'hB4);
		// protection takes one write after the load, later ones ignored
		wr(16'h1824, 8'h3C);
		rd(16'h1824, 8'h3C);
		wr(16'h1824, 8'h11);
		rd(16'h1824, 8'h3C);
		wr(16'h1821, 8'h00);
		rd(16'h1821, 8'h81);
		rd(16'h0021, 8'h00);
		rd(16'h1822, 8'h00);
		// a write with the clock enable low leaves key access clear
		ce_q <= 1'b0;
		wr(16'h1823, 8'h20);
		ce_q <= 1'b1;
		rd(16'h1823, 8'h00);
		// key from debug, from unsecure code, wrong, then right
		wr(16'h1823, 8'h20);
		rd(16'h1823, 8'h20);
		bdm_q <= 1'b1;
		sec_q <= 1'b1;
		key(8'h00, 1'b1);
		bdm_q <= 1'b0;
		sec_q <= 1'b0;
		key(8'h00, 1'b1);
		sec_q <= 1'b1;
		key(8'h04, 1'b1);
		rd(16'h1827, 8'h1D);
		key(8'h00, 1'b0);
		rd(16'h1827, 8'h1E);
		wr(16'h1823, 8'h20);
		rd(16'h1827, 8'h06);
		boot(8'h81);
		chk("secure", secure, 1'b1);
		// key disabled: only a verified blank erase opens
		boot(8'h01);
		wr(16'h1823, 8'h20);
		key(8'h00, 1'b1);
		@(posedge mclk_i);
		blank_q <= 1'b1;
		@(posedge mclk_i);
		blank_q <= 1'b0;
		#1 chk("secure", secure, 1'b0);
		summarize();
	end
endmodule
bind nvsl_top nvsl_top_sva chk_u (.mclk_i, .nrst_i, .ce_i, .addr_i, .rd_i,
	.rdata_o, .blank_ok_i, .nv_addr_o, .nv_rd_o, .nv_rdata_i, .secure_o,
	.key_enable_bit_o, .vector_redirect_disable_o, .protect_boundary_field_o,
	.protect_disable_bit_o, .clock_trim_value_o, .fine_trim_bit_o,
	.load_done_o);
`default_nettype wire
